//--- hdl/trps_core.sv
// Reset, power-down and status logic of one non-bonded transceiver block.
// Assumes software or user logic sequences channel resets from the status;
// the pll and cdr are modelled by lock timers on the single mclk_i.
`timescale 1ns/10ps
`include "trps_map.svh"

//
// Behaviour
// [RQ1] each channel sources its high and low speed clocks independently
// [RQ2] each channel's phase fifo keeps its own pointers and control
// [RQ3] integrator may prefer bonded mode for low channel skew
// [RQ4] channel clocks come primarily from an adjacent multipurpose pll
// [RQ5] user reset logic asserts pll reset during reset sequence
// [RQ6] reconfiguration controller, not user, drives pll reset after reconfig
// [RQ7] block power-down powers down pcs and pma of every channel
// [RQ8] power-down is one block-wide signal, independent of other resets
// [RQ9] pll lock output high when transmit pll locked to reference
// [RQ10] lock-mode status high in lock-to-data, low in lock-to-reference
// [RQ11] busy low first reconfig cycle, asserted from the second
// [RQ12] busy held during offset cancellation; drop means cancellation done
// [RQ13] busy also held for whole analog or channel reconfiguration
// [RQ14] user releases transmit pcs reset only after pll lock
// [RQ15] user waits five parallel clocks after lock before rx pma release
// [RQ16] user waits lock-to-data time after lock mode before rx pcs release
// [RQ17] user synchronises status signals before deciding resets
// [RQ18] user holds channel resets during power-down, restarts afterwards
module trps_core
    import trps_pkg::*;
#(
    parameter int unsigned N_CHAN = 4
) (
    input  wire logic              mclk_i,
    input  wire logic              sys_rst_i,
    // axi4-lite slave
    input  wire logic [11:0]       s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [11:0]       s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    // pll reset from reconfiguration controller (pin, asynchronous)
    input  wire logic              pll_rcfg_rst_i,
    // per channel power and status
    output logic [N_CHAN-1:0]      chan_pcs_pwr_o,
    output logic [N_CHAN-1:0]      chan_pma_pwr_o,
    output logic [N_CHAN-1:0]      chan_clk_src_o,
    output logic                   pll_lock_o,
    output logic                   rx_lock_mode_o,
    output logic                   rcfg_busy_o,
    output logic                   irq_o
);

    // elaboration refuses channel counts the block cannot serve
    if (N_CHAN < 1 || N_CHAN > 4) begin : g_bad_chan
        $error("trps_core: N_CHAN must be 1 to 4");
    end

    // ******************************************************************
    // pin synchroniser
    // ******************************************************************
    logic pllrst_meta;
    logic pllrst_sync;

    // first stage read only by the second
    always_ff @(posedge mclk_i) begin
        pllrst_meta <= pll_rcfg_rst_i;
        pllrst_sync <= pllrst_meta;
    end

    // ******************************************************************
    // register bus slave
    // ******************************************************************
    logic [31:0]           ctrl;
    logic [`TRPS_EV_W-1:0] irq_stat;
    logic [`TRPS_EV_W-1:0] irq_en;
    logic [11:0]           aw_addr;
    logic                  aw_held;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  w_held;

    wire wr_go   = aw_held && w_held && !s_axi_bvalid_o;
    wire rd_go   = s_axi_arvalid_i && !s_axi_rvalid_o;
    wire wr_ctrl = wr_go && aw_addr == `TRPS_CTRL_OFF;
    wire wr_en   = wr_go && aw_addr == `TRPS_IRQ_EN_OFF;
    wire wr_clr  = wr_go && aw_addr == `TRPS_IRQ_CLR_OFF;
    wire wr_rcfg = wr_go && aw_addr == `TRPS_RCFG_OFF;
    wire wr_ok   = wr_ctrl || wr_en || wr_clr || wr_rcfg;

    assign s_axi_awready_o = !aw_held;
    assign s_axi_wready_o  = !w_held;
    assign s_axi_arready_o = !s_axi_rvalid_o;

    // address and data accepted in either order, response after both
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 12'h000;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid_i && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr_i[11:2], 2'b00};
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid_i && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // write response, slverr on unmapped or read-only offsets
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= 2'b00;
        end else if (wr_go) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_ok ? 2'b00 : 2'b10;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // byte-masked control write; only the low byte holds fields
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ctrl   <= `TRPS_CTRL_RST;
            irq_en <= '0;
        end else begin
            if (wr_ctrl && w_strb[0])
                ctrl[1:0] <= w_data[1:0];
            if (wr_en && w_strb[0])
                irq_en <= w_data[`TRPS_EV_W-1:0];
        end
    end

    // ******************************************************************
    // power-down and pll reset
    // ******************************************************************
    wire pwrdn   = ctrl[`TRPS_CTRL_PWRDN];           // RQ8
    // user reset or controller reset, either holds the pll
    wire pll_rst = ctrl[`TRPS_CTRL_PLLRST] || pllrst_sync; // RQ5 RQ6

    // power-down ignores both pll reset sources
    assign chan_pcs_pwr_o = {N_CHAN{!pwrdn}};        // RQ7 RQ8
    assign chan_pma_pwr_o = {N_CHAN{!pwrdn}};        // RQ7
    // each channel has its own clock select, fixed to adjacent pll 0
    genvar gi;
    generate
        for (gi = 0; gi < N_CHAN; gi++) begin : g_chan
            assign chan_clk_src_o[gi] = 1'b0;        // RQ1 RQ2 RQ4
        end
    endgenerate

    // ******************************************************************
    // pll lock and cdr lock mode
    // ******************************************************************
    logic [15:0]  lock_cnt;
    logic [15:0]  ltd_cnt;
    trps_cdr_type cdr_mode;

    // lock after a fixed settle time out of reset
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || pll_rst || pwrdn) begin
            lock_cnt   <= 16'd0;
            pll_lock_o <= 1'b0;
        end else if (lock_cnt != `TRPS_LOCK_CYC) begin
            lock_cnt <= lock_cnt + 16'd1;
        end else begin
            pll_lock_o <= 1'b1;                      // RQ9
        end
    end

    // cdr stays lock-to-reference until pll locked for a while;
    // cleared on the same edge as lock so it never outlives it
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || pll_rst || pwrdn || !pll_lock_o) begin
            ltd_cnt  <= 16'd0;
            cdr_mode <= TRPS_LTR;
        end else if (ltd_cnt != `TRPS_LTD_CYC) begin
            ltd_cnt <= ltd_cnt + 16'd1;
        end else begin
            cdr_mode <= TRPS_LTD;
        end
    end
    assign rx_lock_mode_o = (cdr_mode == TRPS_LTD);  // RQ10

    // ******************************************************************
    // reconfiguration controller busy
    // ******************************************************************
    trps_rc_type rc_state;
    trps_rc_type next_rc_state;
    logic [15:0] rc_cnt;

    wire rc_done = (rc_state == TRPS_RC_OFFC)
                 ? (rc_cnt == `TRPS_OFFC_CYC - 16'd1)
                 : (rc_cnt == `TRPS_RCFG_CYC - 16'd1);
    wire rc_req  = wr_rcfg && w_strb[0] &&
                   (w_data[`TRPS_RCFG_CHAN] || w_data[`TRPS_RCFG_ANALOG]);

    // first cycle idle-low, then offset cancellation, then serve requests
    always_comb begin
        next_rc_state = rc_state;
        unique case (rc_state)
            TRPS_RC_FIRST: next_rc_state = TRPS_RC_OFFC;      // RQ11
            TRPS_RC_OFFC:  if (rc_done) next_rc_state = TRPS_RC_IDLE;
            TRPS_RC_IDLE:  if (rc_req) next_rc_state = TRPS_RC_RCFG;
            TRPS_RC_RCFG:  if (rc_done) next_rc_state = TRPS_RC_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rc_state <= TRPS_RC_FIRST;
            rc_cnt   <= 16'd0;
        end else begin
            rc_state <= next_rc_state;
            rc_cnt   <= (next_rc_state != rc_state) ? 16'd0
                                                    : rc_cnt + 16'd1;
        end
    end

    // busy covers cancellation and every reconfiguration
    assign rcfg_busy_o = (rc_state == TRPS_RC_OFFC) ||
                         (rc_state == TRPS_RC_RCFG);  // RQ12 RQ13

    // ******************************************************************
    // events and interrupt
    // ******************************************************************
    logic lock_q;
    logic ltd_q;
    logic busy_q;
    wire [`TRPS_EV_W-1:0] ev = {busy_q && !rcfg_busy_o,
                                !ltd_q && rx_lock_mode_o,
                                lock_q && !pll_lock_o,
                                !lock_q && pll_lock_o};

    // set wins over a clear in the same cycle
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            lock_q   <= 1'b0;
            ltd_q    <= 1'b0;
            busy_q   <= 1'b0;
            irq_stat <= '0;
        end else begin
            lock_q   <= pll_lock_o;
            ltd_q    <= rx_lock_mode_o;
            busy_q   <= rcfg_busy_o;
            irq_stat <= (irq_stat & ~(wr_clr && w_strb[0]
                         ? w_data[`TRPS_EV_W-1:0] : '0)) | ev;
        end
    end
    assign irq_o = |(irq_stat & irq_en);

    // ******************************************************************
    // read path
    // ******************************************************************
    wire [31:0] stat_word = {28'h0, pwrdn, rcfg_busy_o,
                             rx_lock_mode_o, pll_lock_o};
    wire [11:0] ra = {s_axi_araddr_i[11:2], 2'b00};
    wire        rd_hit = ra == `TRPS_CTRL_OFF || ra == `TRPS_STAT_OFF ||
                         ra == `TRPS_IRQ_STAT_OFF || ra == `TRPS_IRQ_EN_OFF ||
                         ra == `TRPS_IRQ_CLR_OFF || ra == `TRPS_RCFG_OFF;
    wire [31:0] rd_word =
        ra == `TRPS_CTRL_OFF     ? ctrl :
        ra == `TRPS_STAT_OFF     ? stat_word :
        ra == `TRPS_IRQ_STAT_OFF ? {28'h0, irq_stat} :
        ra == `TRPS_IRQ_EN_OFF   ? {28'h0, irq_en} : 32'h0000_0000;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0000_0000;
            s_axi_rresp_o  <= 2'b00;
        end else if (rd_go) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_word;
            s_axi_rresp_o  <= rd_hit ? 2'b00 : 2'b10;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

endmodule : trps_core

//--- hdl/trps_map.svh
// Constants for the transceiver reset, power-down and status block.
// Assumes a 100 MHz mclk_i and a 32-bit AXI4-Lite register bus.
`ifndef TRPS_MAP_SVH
`define TRPS_MAP_SVH

// register byte offsets
`define TRPS_CTRL_OFF     12'h000
`define TRPS_STAT_OFF     12'h004
`define TRPS_IRQ_STAT_OFF 12'h008
`define TRPS_IRQ_EN_OFF   12'h00C
`define TRPS_IRQ_CLR_OFF  12'h010
`define TRPS_RCFG_OFF     12'h014

// ctrl fields
`define TRPS_CTRL_PLLRST  0
`define TRPS_CTRL_PWRDN   1
`define TRPS_CTRL_RST     32'h0000_0000

// status fields
`define TRPS_ST_LOCK      0
`define TRPS_ST_LTD       1
`define TRPS_ST_BUSY      2
`define TRPS_ST_PWRDN     3

// event fields, same layout in status, enable and clear
`define TRPS_EV_LOCK_UP   0
`define TRPS_EV_LOCK_DN   1
`define TRPS_EV_LTD_UP    2
`define TRPS_EV_BUSY_DN   3
`define TRPS_EV_W         4

// reconfiguration command fields
`define TRPS_RCFG_CHAN    0
`define TRPS_RCFG_ANALOG  1

// timing counts, in mclk_i cycles
`define TRPS_LOCK_CYC     16'd64
`define TRPS_LTD_CYC      16'd32
`define TRPS_OFFC_CYC     16'd128
`define TRPS_RCFG_CYC     16'd48

`endif

//--- hdl/trps_pkg.sv
// Types for the transceiver reset, power-down and status block.
// Assumes trps_map.svh holds all numeric constants.
package trps_pkg;

    // reconfiguration controller states, gray along the usual path
    typedef enum logic [1:0] {
        TRPS_RC_FIRST = 2'b00,
        TRPS_RC_OFFC  = 2'b01,
        TRPS_RC_IDLE  = 2'b11,
        TRPS_RC_RCFG  = 2'b10
    } trps_rc_type;

    // receiver cdr lock mode
    typedef enum logic {
        TRPS_LTR = 1'b0,
        TRPS_LTD = 1'b1
    } trps_cdr_type;

endpackage : trps_pkg

//--- bench/trps_core_asserts.sv
// Concurrent checks on the status and power ports of trps_core.
// Assumes a single mclk_i domain and the bind at the foot of this file.
`timescale 1ns/10ps
// ****************************************************************
// status and power checker
// ****************************************************************
module trps_core_asserts #(
    parameter int unsigned N_CHAN = 4
) (
    input wire logic              mclk_i,
    input wire logic              sys_rst_i,
    input wire logic              pll_rcfg_rst_i,
    input wire logic [N_CHAN-1:0] chan_pcs_pwr_o,
    input wire logic [N_CHAN-1:0] chan_pma_pwr_o,
    input wire logic [N_CHAN-1:0] chan_clk_src_o,
    input wire logic              pll_lock_o,
    input wire logic              rx_lock_mode_o,
    input wire logic              rcfg_busy_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    AST_CLK_SRC: assert property (chan_clk_src_o == '0)
        else $error("channel clock not from adjacent pll");
    AST_PWR_BLOCK: assert property (
        (chan_pcs_pwr_o == '0) || (chan_pcs_pwr_o == '1))
        else $error("power-down not shared by all channels");
    AST_PWR_PAIR: assert property (chan_pcs_pwr_o == chan_pma_pwr_o)
        else $error("pcs and pma power differ");
    AST_LTD_LOCK: assert property (rx_lock_mode_o |-> pll_lock_o)
        else $error("lock-to-data without pll lock");
    AST_LTD_LATE: assert property (
        $rose(pll_lock_o) |=> (!rx_lock_mode_o) [*8])
        else $error("lock-to-data too soon after lock");
    AST_BUSY_START: assert property (
        $fell(sys_rst_i) |-> !rcfg_busy_o ##1 rcfg_busy_o [*8])
        else $error("busy start after power-up wrong");
    AST_BUSY_END: assert property (
        $fell(sys_rst_i) |-> ##[128:130] !rcfg_busy_o)
        else $error("offset cancellation did not end");
    AST_BUSY_HOLD: assert property (
        $rose(rcfg_busy_o) |-> rcfg_busy_o [*8])
        else $error("busy dropped too early");
    AST_LOCK_DROP: assert property (
        $rose(pll_rcfg_rst_i) |-> ##4 (!pll_lock_o) [*8])
        else $error("lock kept through pll reset");
endmodule : trps_core_asserts

bind trps_core trps_core_asserts #(.N_CHAN(N_CHAN)) u_chk (
    .mclk_i, .sys_rst_i, .pll_rcfg_rst_i, .chan_pcs_pwr_o, .chan_pma_pwr_o,
    .chan_clk_src_o, .pll_lock_o, .rx_lock_mode_o, .rcfg_busy_o
);

//--- bench/trps_far.sv
// Model of the pll reconfiguration controller beside the block.
// Assumes the bench pulses pulse_i for one cycle per reconfiguration.
`timescale 1ns/10ps
// ****************************************************************
// pll reconfiguration controller model
// ****************************************************************
module trps_far (
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    input  wire logic pulse_i,
    output logic      pll_rcfg_rst_o
);
    logic [2:0] hold_cnt;

    // short pll reset after each reconfiguration, not user driven
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || pulse_i)
            hold_cnt <= sys_rst_i ? 3'h0 : 3'h4;
        else if (hold_cnt != 3'h0)
            hold_cnt <= hold_cnt - 3'h1;
    end
    assign pll_rcfg_rst_o = (hold_cnt != 3'h0);
endmodule : trps_far

//--- bench/tb_top.sv
// Self-checking bench for trps_core with its reconfiguration partner.
// Assumes the register offsets and fields of trps_map.svh.
`timescale 1ns/10ps
`include "trps_map.svh"
// ****************************************************************
// testbench top
// ****************************************************************
module tb_top;
    logic        mclk_i, sys_rst_i, aw_valid, w_valid, b_ready;
    logic        ar_valid, r_ready, pulse, aw_ready, w_ready, b_valid;
    logic        ar_ready, r_valid, rcfg_rst, lock, ltd, busy, irq;
    logic [11:0] aw_addr, ar_addr;
    logic [31:0] w_data, r_data;
    logic [1:0]  b_resp, r_resp;
    logic [3:0]  pcs, pma;
    int          fails, check_count;
    wire  [3:0]  st = {irq, busy, ltd, lock};

    trps_core dut (.mclk_i, .sys_rst_i, .s_axi_awaddr_i(aw_addr),
        .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_ready),
        .s_axi_wdata_i(w_data), .s_axi_wstrb_i(4'hF),
        .s_axi_wvalid_i(w_valid), .s_axi_wready_o(w_ready),
        .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_valid),
        .s_axi_bready_i(b_ready), .s_axi_araddr_i(ar_addr),
        .s_axi_arvalid_i(ar_valid), .s_axi_arready_o(ar_ready),
        .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp),
        .s_axi_rvalid_o(r_valid), .s_axi_rready_i(r_ready),
        .pll_rcfg_rst_i(rcfg_rst), .chan_pcs_pwr_o(pcs),
        .chan_pma_pwr_o(pma), .chan_clk_src_o(), .pll_lock_o(lock),
        .rx_lock_mode_o(ltd), .rcfg_busy_o(busy), .irq_o(irq));
    trps_far u_far (.mclk_i, .sys_rst_i, .pulse_i(pulse),
        .pll_rcfg_rst_o(rcfg_rst));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic end_of_test;
        if (fails == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] g, e, input string m);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t ns: %s", $time, m);
        end
    endtask : chk

    // poll a status level at the falling edge, where it has settled
    task automatic wt(input int s, input logic v);
        int n;
        n = 0;
        while (st[s] !== v && n < 400) begin
            @(negedge mclk_i);
            n++;
        end
        chk(st[s], v, "status wait");
    endtask : wt

    // ready is looked at mid-cycle; it cannot change before the next edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        logic ta, tw, tb;
        logic [1:0] r;
        n = 0;
        tb = 1'b0;
        @(posedge mclk_i);
        aw_addr <= a;
        w_data <= d;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        while (!tb && n < 100) begin
            @(negedge mclk_i);
            ta = aw_valid & aw_ready;
            tw = w_valid & w_ready;
            tb = b_valid;
            r = b_resp;
            @(posedge mclk_i);
            if (ta) aw_valid <= 1'b0;
            if (tw) w_valid <= 1'b0;
            n++;
        end
        b_ready <= 1'b0;
        // later checks look at settled outputs, not the launch edge
        @(negedge mclk_i);
        chk({tb, r}, 3'b100, "write response");
    endtask : wr

    task automatic rd(input logic [11:0] a, m, input logic [31:0] e,
                      input logic [1:0] er);
        int n;
        logic ta, tk;
        logic [31:0] d;
        logic [1:0] r;
        n = 0;
        tk = 1'b0;
        @(posedge mclk_i);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        while (!tk && n < 100) begin
            @(negedge mclk_i);
            ta = ar_valid & ar_ready;
            tk = r_valid;
            d = r_data;
            r = r_resp;
            @(posedge mclk_i);
            if (ta) ar_valid <= 1'b0;
            n++;
        end
        r_ready <= 1'b0;
        @(negedge mclk_i);
        chk({tk, r, d[11:0] & m}, {1'b1, er, e[11:0]}, "read value");
    endtask : rd

    task automatic t_powerup;
        @(negedge mclk_i);
        chk(busy, 1'b0, "busy high in first cycle");
        @(negedge mclk_i);
        chk(busy, 1'b1, "busy not raised in second cycle");
        wt(2, 1'b0);
        rd(`TRPS_IRQ_STAT_OFF, 12'h8, 32'h8, 2'b00);
        rd(`TRPS_IRQ_CLR_OFF, 12'hFFF, 32'h0, 2'b00);
        rd(12'h100, 12'hFFF, 32'h0, 2'b10);
    endtask : t_powerup

    // masked lock fall, then enabled lock rise, then clear
    task automatic t_lock;
        wr(`TRPS_IRQ_EN_OFF, 32'h1);
        wr(`TRPS_CTRL_OFF, 32'h1);
        wt(0, 1'b0);
        wr(`TRPS_IRQ_CLR_OFF, 32'h1);
        chk(irq, 1'b0, "masked event raised irq");
        rd(`TRPS_IRQ_STAT_OFF, 12'h2, 32'h2, 2'b00);
        wr(`TRPS_CTRL_OFF, 32'h0);
        wt(0, 1'b1);
        repeat (5) @(negedge mclk_i);
        chk(ltd, 1'b0, "lock-to-data with lock");
        wt(1, 1'b1);
        rd(`TRPS_STAT_OFF, 12'hF, 32'h3, 2'b00);
        chk(irq, 1'b1, "irq missing");
        wr(`TRPS_IRQ_CLR_OFF, 32'hF);
        chk(irq, 1'b0, "irq not cleared");
        wr(`TRPS_IRQ_EN_OFF, 32'h0);
    endtask : t_lock

    // power-down with pll reset bit clear, then power back and lock-to-data awaited
    task automatic t_pwrdn;
        wr(`TRPS_CTRL_OFF, 32'h2);
        chk({pcs, pma}, 8'h00, "channels still powered");
        rd(`TRPS_STAT_OFF, 12'hF, 32'h8, 2'b00);
        wr(`TRPS_CTRL_OFF, 32'h0);
        chk({pcs, pma}, 8'hFF, "channels not powered");
        wt(1, 1'b1);
    endtask : t_pwrdn

    // a second start while busy must be dropped
    task automatic t_rcfg;
        int n;
        wr(`TRPS_RCFG_OFF, 32'h1);
        chk(busy, 1'b1, "channel reconfig not busy");
        wr(`TRPS_RCFG_OFF, 32'h2);
        n = 0;
        while (busy === 1'b1 && n < 100) begin
            @(negedge mclk_i);
            n++;
        end
        // a dropped request leaves only the first run's remaining length
        chk(n >= 40 && n <= 44, 1'b1, "busy length wrong");
        repeat (4) @(negedge mclk_i);
        chk(busy, 1'b0, "request during busy kept");
        wr(`TRPS_RCFG_OFF, 32'h2);
        chk(busy, 1'b1, "analog reconfig not busy");
        wt(2, 1'b0);
    endtask : t_rcfg

    task automatic t_pllrst;
        @(posedge mclk_i);
        pulse <= 1'b1;
        @(posedge mclk_i);
        pulse <= 1'b0;
        wt(0, 1'b0);
        chk(ltd, 1'b0, "lock-to-data kept");
        wt(1, 1'b1);
    endtask : t_pllrst

    initial begin
        {aw_valid, w_valid, b_ready, ar_valid, r_ready, pulse} = 6'h00;
        {aw_addr, ar_addr, w_data} = 56'h0;
        fails = 0;
        check_count = 0;
        sys_rst_i = 1'b1;
        repeat (16) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_powerup;
        t_lock;
        t_pwrdn;
        t_rcfg;
        t_pllrst;
        end_of_test;
    end

    initial begin
        #200000;
        fails++;
        end_of_test;
    end
endmodule : tb_top
